// *** hdl/pll_synth_params.svh ***
// Constants for the PLL synthesizer mode and disable control block.
`ifndef PLL_SYNTH_PARAMS_SVH
`define PLL_SYNTH_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and bus
// ----------------------------------------------------------------------
`define CLK_HZ 100000000
`define ADDR_W 12
`define DATA_W 32

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_DIVISION_SYSTEM_SELECT 12'h021
`define IDX_REFERENCE_FREQUENCY_SELECT 12'h031
`define IDX_DIVISION_VALUE 12'h041
`define IDX_SYNTH_STATUS 12'h051

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DSS_RESET 4'h0
`define RFS_RESET 4'hf
`define DIV_VALUE_RESET 16'h0000

// ----------------------------------------------------------------------
// Division system codes
// ----------------------------------------------------------------------
`define DSS_VCO_OFF 4'h0
`define DSS_DIRECT 4'h1
`define DSS_HIGH_SWALLOW 4'h2
`define DSS_MIDDLE_SWALLOW 4'h3
`define DIRECT_SHIFT 4

// ----------------------------------------------------------------------
// Reference frequency codes and figures in Hz
// ----------------------------------------------------------------------
`define RFS_5K 4'h2
`define RFS_12K5 4'h5
`define RFS_25K 4'h6
`define RFS_50K 4'h7
`define RFS_3K 4'h8
`define RFS_1K 4'hc
`define RFS_9K 4'hd
`define RFS_100K 4'he
`define RFS_DISABLE 4'hf
`define FR_HZ_5K 5000
`define FR_HZ_12K5 12500
`define FR_HZ_25K 25000
`define FR_HZ_50K 50000
`define FR_HZ_3K 3000
`define FR_HZ_1K 1000
`define FR_HZ_9K 9000
`define FR_HZ_100K 100000

// ----------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------
`define ST_FULL_DISABLE 0
`define ST_VCO_OFF 1
`define ST_REF_INHIBIT 2
`define ST_UP 3
`define ST_DOWN 4

`endif

// *** hdl/pll_synth_pkg.sv ***
// Types shared by the PLL synthesizer mode and disable control block.
package pll_synth_pkg;

    typedef enum logic [2:0] {
        div_off,
        div_direct,
        div_middle,
        div_high,
        div_inhibit
    } division_mode_type;

    typedef enum logic [1:0] {
        pump_float,
        pump_up,
        pump_down
    } pump_state_type;

    typedef struct packed {
        logic [3:0] system_sel;
        logic [3:0] ref_sel;
        logic [15:0] value;
    } synth_config_type;

    typedef struct packed {
        logic down;
        logic up;
        logic ref_inhibit;
        logic vco_off;
        logic full_disable;
    } synth_status_type;

endpackage : pll_synth_pkg

// *** hdl/pll_synth_mode_and_disable_control.sv ***
// PLL synthesizer mode select, divider, comparator and disable control.
`timescale 1ns/100ps
`include "pll_synth_params.svh"

// Notes on behaviour
// (RQ1) Chip enable low halts the whole synthesizer whatever the registers hold.
// (RQ2) Reference select all ones halts the synthesizer even with chip enable high.
// (RQ3) Division select zero pulls VCO inputs down; the rest keeps running.
// (RQ4) Full disable: VCO pulled down, divider stopped, outputs silent, error floats.
// (RQ5) Full disable pulls the loop amplifier input down.
// (RQ6) VCO-off mode: pump keeps running, usually driving error output low.
// (RQ7) Chip-enable reset keeps both mode select registers unchanged.
// (RQ8) Software writes the disable code itself if it wants disable later.
// (RQ9) Power-on reset loads reference select with all ones.
// (RQ10) Clock stop loads reference select with all ones.
// (RQ11) Without clock stop, reference select keeps its value over chip reset.
// (RQ12) Halt with chip enable high leaves configuration untouched.
// (RQ13) Direct division takes the low-band VCO input only.
// (RQ14) Middle-band pulse swallow takes the low-band VCO input.
// (RQ15) High-band pulse swallow takes the high-band VCO input.
// (RQ16) Divider divides selected input by the division value.
// (RQ17) The three registers sit at their fixed register indices.
// (RQ18) Division select code 0001 means direct division on low band.
// (RQ19) Codes 0011 and 0010 select middle and high band swallow.
// (RQ20) Reference codes 1101, 0010, 0110 give 9, 5 and 25 kHz.
// (RQ21) Comparator asks up when slow, down when fast; pump low/high/float.
// (RQ22) Direct division ignores the lowest nibble of the division value.
// (RQ23) Mode changes apply at the next reference period boundary; vco_pulldown and full disable follow the registers at once.
module pll_synth_mode_and_disable_control #(
    parameter int unsigned CLOCK_HZ = `CLK_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [`DATA_W-1:0] pwdata,
    output logic [`DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_enable,
    input wire logic clock_stop,
    input wire logic low_band_vco_input,
    input wire logic high_band_vco_input,
    output logic vco_pulldown,
    output logic loop_amp_pulldown,
    output logic err_out,
    output logic err_oe,
    output logic ref_pulse,
    output logic div_pulse
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [`ADDR_W-1:0] byte_addr(
        input logic [`ADDR_W-1:0] idx
    );
        byte_addr = {idx[`ADDR_W-3:0], 2'b00};
    endfunction : byte_addr

    function automatic pll_synth_pkg::division_mode_type decode_mode(
        input logic [3:0] code
    );
        case (code)
            `DSS_VCO_OFF: decode_mode = pll_synth_pkg::div_off;
            // (RQ18) Direct division code.
            `DSS_DIRECT: decode_mode = pll_synth_pkg::div_direct;
            // (RQ19) Swallow band codes.
            `DSS_MIDDLE_SWALLOW: decode_mode = pll_synth_pkg::div_middle;
            `DSS_HIGH_SWALLOW: decode_mode = pll_synth_pkg::div_high;
            default: decode_mode = pll_synth_pkg::div_inhibit;
        endcase
    endfunction : decode_mode

    // A zero period marks a code with no reference output.
    function automatic logic [31:0] ref_period(input logic [3:0] code);
        logic [31:0] hz;
        hz = 32'h0000_0000;
        case (code)
            // (RQ20) Reference frequency decode.
            `RFS_9K: hz = `FR_HZ_9K;
            `RFS_5K: hz = `FR_HZ_5K;
            `RFS_25K: hz = `FR_HZ_25K;
            `RFS_12K5: hz = `FR_HZ_12K5;
            `RFS_50K: hz = `FR_HZ_50K;
            `RFS_3K: hz = `FR_HZ_3K;
            `RFS_1K: hz = `FR_HZ_1K;
            `RFS_100K: hz = `FR_HZ_100K;
            default: hz = 32'h0000_0000;
        endcase
        if (hz == 32'h0000_0000) begin
            ref_period = 32'h0000_0000;
        end else if (CLOCK_HZ < hz) begin
            ref_period = 32'h0000_0001;
        end else begin
            ref_period = 32'(CLOCK_HZ / hz);
        end
    endfunction : ref_period

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [3:0] division_system_select_q;
    logic [3:0] reference_frequency_select_q;
    logic [15:0] division_value_q;
    pll_synth_pkg::synth_config_type active_q;
    pll_synth_pkg::division_mode_type mode;
    pll_synth_pkg::pump_state_type pump_q;
    pll_synth_pkg::pump_state_type pump_d;
    pll_synth_pkg::synth_status_type status;
    logic [31:0] ref_cnt_q;
    logic [31:0] period;
    logic ref_tick;
    logic [15:0] div_cnt_q;
    logic [15:0] div_n;
    logic vco_prev_q;
    logic vco_sel;
    logic vco_edge;
    logic fn_tick;
    logic full_disable;
    logic ref_idle;
    logic setup;
    logic wr;
    logic hit_dss;
    logic hit_rfs;
    logic hit_dv;
    logic hit_st;
    logic [`DATA_W-1:0] rd_d;
    logic [`DATA_W-1:0] prdata_q;
    logic err_out_q;
    logic err_oe_q;
    logic vco_pulldown_q;
    logic loop_amp_pulldown_q;
    logic ref_pulse_q;
    logic div_pulse_q;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // (RQ17) Fixed register indices.
    assign hit_dss = paddr == byte_addr(`IDX_DIVISION_SYSTEM_SELECT);
    assign hit_rfs = paddr == byte_addr(`IDX_REFERENCE_FREQUENCY_SELECT);
    assign hit_dv = paddr == byte_addr(`IDX_DIVISION_VALUE);
    assign hit_st = paddr == byte_addr(`IDX_SYNTH_STATUS);
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    // Zero wait states keep the bus simple; read data is caught at setup.
    assign pready = 1'b1;
    assign pslverr = psel && penable
        && !(hit_dss || hit_rfs || hit_dv || (hit_st && !pwrite));

    always_comb begin
        rd_d = '0;
        if (hit_dss) begin
            rd_d[3:0] = division_system_select_q;
        end else if (hit_rfs) begin
            rd_d[3:0] = reference_frequency_select_q;
        end else if (hit_dv) begin
            rd_d[15:0] = division_value_q;
        end else if (hit_st) begin
            rd_d[4:0] = status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_d;
        end
    end

    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // (RQ7) Chip enable never resets the mode selects.
    // (RQ12) Only writes and clock stop change the configuration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            division_system_select_q <= `DSS_RESET;
        end else if (wr && hit_dss) begin
            division_system_select_q <= pwdata[3:0];
        end
    end

    // (RQ9) Power-on reset enters full disable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_frequency_select_q <= `RFS_RESET;
        // (RQ10) Clock stop forces disable.
        end else if (clock_stop) begin
            reference_frequency_select_q <= `RFS_DISABLE;
        // (RQ11) Otherwise value is held.
        end else if (wr && hit_rfs) begin
            reference_frequency_select_q <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            division_value_q <= `DIV_VALUE_RESET;
        end else if (wr && hit_dv) begin
            division_value_q <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Disable decode
    // ------------------------------------------------------------------
    // (RQ1) Chip enable low halts.
    // (RQ2) Disable code halts.
    assign full_disable = !chip_enable
        || (reference_frequency_select_q == `RFS_DISABLE);
    assign mode = decode_mode(active_q.system_sel);
    assign period = ref_period(active_q.ref_sel);
    assign ref_idle = full_disable || (period == 32'h0000_0000);

    // ------------------------------------------------------------------
    // Active configuration
    // ------------------------------------------------------------------
    // (RQ23) Apply new modes at period boundary.
    // An idle generator has no boundary, so it takes a new setting at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= {`DSS_RESET, `RFS_RESET, `DIV_VALUE_RESET};
        end else if (ref_tick || ref_idle) begin
            active_q.system_sel <= division_system_select_q;
            active_q.ref_sel <= reference_frequency_select_q;
            active_q.value <= division_value_q;
        end
    end

    // ------------------------------------------------------------------
    // Reference generator
    // ------------------------------------------------------------------
    assign ref_tick = !ref_idle && (ref_cnt_q + 32'h1 >= period);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_cnt_q <= '0;
        // (RQ4) Reference output stops.
        end else if (ref_idle || ref_tick) begin
            ref_cnt_q <= '0;
        end else begin
            ref_cnt_q <= ref_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // VCO input selection and programmable divider
    // ------------------------------------------------------------------
    always_comb begin
        vco_sel = 1'b0;
        case (mode)
            // (RQ13) Direct uses low band.
            pll_synth_pkg::div_direct: vco_sel = low_band_vco_input;
            // (RQ14) Middle swallow uses low band.
            pll_synth_pkg::div_middle: vco_sel = low_band_vco_input;
            // (RQ15) High swallow uses high band.
            pll_synth_pkg::div_high: vco_sel = high_band_vco_input;
            default: vco_sel = 1'b0;
        endcase
    end

    // (RQ22) Direct division drops the low nibble.
    assign div_n = (mode == pll_synth_pkg::div_direct)
        ? (active_q.value >> `DIRECT_SHIFT) : active_q.value;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_prev_q <= 1'b0;
        end else begin
            vco_prev_q <= vco_sel;
        end
    end

    assign vco_edge = vco_sel && !vco_prev_q && !full_disable;
    // (RQ16) One output pulse per division value edges.
    assign fn_tick = vco_edge && (div_cnt_q + 16'h1 >= div_n);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= '0;
        // (RQ4) Divider stops.
        end else if (full_disable || fn_tick) begin
            div_cnt_q <= '0;
        end else if (vco_edge) begin
            div_cnt_q <= div_cnt_q + 16'h1;
        end
    end

    // ------------------------------------------------------------------
    // Phase comparator
    // ------------------------------------------------------------------
    // (RQ21) Up when divided edge lags, down when it leads.
    // (RQ6) With no divided input the comparator sits in up.
    always_comb begin
        pump_d = pump_q;
        case (pump_q)
            pll_synth_pkg::pump_float: begin
                if (ref_tick && !fn_tick) begin
                    pump_d = pll_synth_pkg::pump_up;
                end else if (fn_tick && !ref_tick) begin
                    pump_d = pll_synth_pkg::pump_down;
                end
            end
            pll_synth_pkg::pump_up: begin
                if (fn_tick) begin
                    pump_d = pll_synth_pkg::pump_float;
                end
            end
            pll_synth_pkg::pump_down: begin
                if (ref_tick) begin
                    pump_d = pll_synth_pkg::pump_float;
                end
            end
            default: pump_d = pll_synth_pkg::pump_float;
        endcase
        // (RQ4) Comparator output stops.
        if (full_disable) begin
            pump_d = pll_synth_pkg::pump_float;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_q <= pll_synth_pkg::pump_float;
        end else begin
            pump_q <= pump_d;
        end
    end

    // ------------------------------------------------------------------
    // Charge pump and pin controls
    // ------------------------------------------------------------------
    // (RQ21) Up drives low, down drives high, otherwise float.
    // (RQ4) Full disable floats the error output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_out_q <= 1'b0;
            err_oe_q <= 1'b0;
        end else begin
            err_out_q <= pump_d == pll_synth_pkg::pump_down;
            err_oe_q <= pump_d != pll_synth_pkg::pump_float;
        end
    end

    // (RQ3) VCO-off code pulls inputs down only.
    // (RQ4) Full disable pulls inputs down.
    // (RQ5) Full disable pulls amplifier input down.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_pulldown_q <= 1'b1;
            loop_amp_pulldown_q <= 1'b1;
        end else begin
            vco_pulldown_q <= full_disable
                || (division_system_select_q == `DSS_VCO_OFF);
            loop_amp_pulldown_q <= full_disable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_pulse_q <= 1'b0;
            div_pulse_q <= 1'b0;
        end else begin
            ref_pulse_q <= ref_tick;
            div_pulse_q <= fn_tick;
        end
    end

    // ------------------------------------------------------------------
    // Status and outputs
    // ------------------------------------------------------------------
    assign status.full_disable = full_disable;
    assign status.vco_off = mode == pll_synth_pkg::div_off;
    assign status.ref_inhibit = period == 32'h0000_0000;
    assign status.up = pump_q == pll_synth_pkg::pump_up;
    assign status.down = pump_q == pll_synth_pkg::pump_down;

    assign err_out = err_out_q;
    assign err_oe = err_oe_q;
    assign vco_pulldown = vco_pulldown_q;
    assign loop_amp_pulldown = loop_amp_pulldown_q;
    assign ref_pulse = ref_pulse_q;
    assign div_pulse = div_pulse_q;

endmodule : pll_synth_mode_and_disable_control

// *** testbench/pll_synth_props.sv ***
// Port assertions for the synthesizer mode and disable control block.
`timescale 1ns/100ps
`include "pll_synth_params.svh"

module pll_synth_props #(
    parameter int unsigned CLOCK_HZ = 100000000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [`DATA_W-1:0] pwdata,
    input wire logic [`DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chip_enable,
    input wire logic clock_stop,
    input wire logic low_band_vco_input,
    input wire logic high_band_vco_input,
    input wire logic vco_pulldown,
    input wire logic loop_amp_pulldown,
    input wire logic err_out,
    input wire logic err_oe,
    input wire logic ref_pulse,
    input wire logic div_pulse
);
    logic mapped;
    assign mapped = paddr == (`IDX_DIVISION_SYSTEM_SELECT << 2)
        || paddr == (`IDX_REFERENCE_FREQUENCY_SELECT << 2)
        || paddr == (`IDX_DIVISION_VALUE << 2)
        || paddr == (`IDX_SYNTH_STATUS << 2);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ce_low_pulls: assert property (
        !chip_enable |=> vco_pulldown && loop_amp_pulldown)
        else $error("pulldowns missing while chip enable is low");
    a_ce_low_float: assert property (
        !chip_enable [*2] |=> !err_oe)
        else $error("error output driven while chip enable is low");
    a_ce_low_stop: assert property (
        !chip_enable [*2] |=> !ref_pulse && !div_pulse)
        else $error("pulses seen while chip enable is low");
    a_amp_with_vco: assert property (
        loop_amp_pulldown |-> vco_pulldown)
        else $error("amplifier pulled down without vco pulldown");
    a_disable_float: assert property (
        loop_amp_pulldown [*3] |-> !err_oe && !ref_pulse)
        else $error("full disable still drives or pulses");
    a_vco_off_quiet: assert property (
        vco_pulldown [*4] |-> !div_pulse)
        else $error("divider pulse with vco inputs pulled down");
    a_unmapped_err: assert property (
        psel && penable && !mapped |-> pslverr)
        else $error("no error response for unmapped address");
    a_err_idle_low: assert property (
        !(psel && penable) |-> !pslverr)
        else $error("error response outside access phase");
    a_read_hold: assert property (
        psel && penable && !pwrite |=> $stable(prdata))
        else $error("read data changed after access");
endmodule : pll_synth_props

// *** testbench/vco_model.sv ***
// Behavioural VCO pair feeding the two band inputs of the synthesizer.
`timescale 1ns/100ps

module vco_model #(
    parameter int LOW_HALF = 1,
    parameter int HIGH_HALF = 3
) (
    input wire logic pclk,
    input wire logic vco_pulldown,
    output logic low_band_vco_input,
    output logic high_band_vco_input
);
    int low_cnt = 0;
    int high_cnt = 0;
    logic low_osc = 1'b0;
    logic high_osc = 1'b0;

    // The oscillators free-run; only the pins are clamped below.
    always @(posedge pclk) begin
        low_cnt <= (low_cnt + 1) % LOW_HALF;
        high_cnt <= (high_cnt + 1) % HIGH_HALF;
        if (low_cnt == LOW_HALF - 1) low_osc <= ~low_osc;
        if (high_cnt == HIGH_HALF - 1) high_osc <= ~high_osc;
    end

    assign low_band_vco_input = vco_pulldown ? 1'b0 : low_osc;
    assign high_band_vco_input = vco_pulldown ? 1'b0 : high_osc;
endmodule : vco_model

// *** testbench/pll_synth_mode_and_disable_control_test.sv ***
// Self-checking bench for the synthesizer mode and disable control block.
`timescale 1ns/100ps
`include "pll_synth_params.svh"

module pll_synth_mode_and_disable_control_test;
    localparam int unsigned RATE = 100000;
    localparam int WIN = 360;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`ADDR_W-1:0] paddr = 12'h000;
    logic [`DATA_W-1:0] pwdata = 32'h0;
    logic [`DATA_W-1:0] prdata;
    logic pready, pslverr, low_in, high_in, vco_pd, amp_pd;
    logic chip_enable = 1'b1;
    logic clock_stop = 1'b0;
    logic err_out, err_oe, ref_pulse, div_pulse, er;
    logic [31:0] rd;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int dss = 0;
    int rfs = 15;
    int dv = 0;
    int n_ref, n_div, n_up, n_dn;
    int t_dss[5] = '{1, 3, 2, 0, 1};
    int t_rfs[5] = '{13, 2, 6, 13, 15};
    int t_dv[5] = '{'h33, 3, 3, 3, 'h30};

    pll_synth_mode_and_disable_control #(.CLOCK_HZ(RATE)) i_pll_synth_mode_and_disable_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
        .clock_stop(clock_stop), .low_band_vco_input(low_in),
        .high_band_vco_input(high_in), .vco_pulldown(vco_pd),
        .loop_amp_pulldown(amp_pd), .err_out(err_out), .err_oe(err_oe),
        .ref_pulse(ref_pulse), .div_pulse(div_pulse));

    vco_model i_vco_model (.pclk(pclk), .vco_pulldown(vco_pd),
        .low_band_vco_input(low_in), .high_band_vco_input(high_in));

    initial forever #5 pclk = ~pclk;

    // A hang is cut short well past the expected run length.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Counts drift by one with the window phase, so allow that much.
    task automatic near(input int seen, input int exp);
        check((seen >= exp - 1 && seen <= exp + 1) ? exp : seen, exp);
    endtask : near

    task automatic apb(input logic wr, input logic [`ADDR_W-1:0] idx,
            input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= idx << 2;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic put(input logic [`ADDR_W-1:0] idx, input int val);
        apb(1'b1, idx, val);
        if (idx == `IDX_DIVISION_SYSTEM_SELECT) dss = val & 15;
        if (idx == `IDX_REFERENCE_FREQUENCY_SELECT) rfs = val & 15;
        if (idx == `IDX_DIVISION_VALUE) dv = val & 'hffff;
    endtask : put

    task automatic get(input logic [`ADDR_W-1:0] idx, input int exp);
        apb(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask : get

    task automatic expect_synth();
        int per;
        int dper;
        bit off;
        off = !chip_enable || rfs == 15;
        per = rfs == 13 ? RATE / 9000 : rfs == 2 ? RATE / 5000 : RATE / 25000;
        dper = dss == 1 ? 2 * (dv >> 4) : dss == 3 ? 2 * dv : 6 * dv;
        if (dss == 0 || off) dper = 0;
        n_ref = 0;
        n_div = 0;
        n_up = 0;
        n_dn = 0;
        repeat (WIN) begin
            @(negedge pclk);
            n_ref += (ref_pulse === 1'b1);
            n_div += (div_pulse === 1'b1);
            n_up += (err_oe === 1'b1 && err_out === 1'b0);
            n_dn += (err_oe === 1'b1 && err_out === 1'b1);
        end
        near(n_ref, off ? 0 : WIN / per);
        near(n_div, dper ? WIN / dper : 0);
        check(vco_pd, off || dss == 0);
        check(amp_pd, off);
        check({n_dn > n_up, n_up > n_dn}, off ? 0 : dper && dper < per ? 2 : 1);
    endtask : expect_synth

    initial begin
        void'($urandom(32));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        get(`IDX_REFERENCE_FREQUENCY_SELECT, 15);
        get(`IDX_DIVISION_SYSTEM_SELECT, 0);
        get(`IDX_DIVISION_VALUE, 0);
        get(`IDX_SYNTH_STATUS, 7);
        check(vco_pd & amp_pd, 1);
        apb(1'b0, 12'h07f, 32'h0);
        check(er, 1);
        check(rd, 0);
        apb(1'b1, `IDX_SYNTH_STATUS, 32'h1);
        check(er, 1);
        repeat (4) begin
            put(`IDX_DIVISION_VALUE, $urandom);
            get(`IDX_DIVISION_VALUE, dv);
            put(`IDX_DIVISION_SYSTEM_SELECT, $urandom);
            get(`IDX_DIVISION_SYSTEM_SELECT, dss);
        end
        for (int i = 0; i < 5; i++) begin
            put(`IDX_DIVISION_VALUE, t_dv[i]);
            put(`IDX_DIVISION_SYSTEM_SELECT, t_dss[i]);
            put(`IDX_REFERENCE_FREQUENCY_SELECT, t_rfs[i]);
            repeat (40) @(posedge pclk);
            expect_synth();
            get(`IDX_DIVISION_VALUE, dv);
        end
        put(`IDX_REFERENCE_FREQUENCY_SELECT, 13);
        chip_enable <= 1'b0;
        repeat (5) @(posedge pclk);
        expect_synth();
        get(`IDX_REFERENCE_FREQUENCY_SELECT, 13);
        get(`IDX_DIVISION_SYSTEM_SELECT, 1);
        chip_enable <= 1'b1;
        repeat (40) @(posedge pclk);
        expect_synth();
        chip_enable <= 1'b0;
        put(`IDX_REFERENCE_FREQUENCY_SELECT, 15);
        chip_enable <= 1'b1;
        repeat (5) @(posedge pclk);
        expect_synth();
        put(`IDX_REFERENCE_FREQUENCY_SELECT, 6);
        chip_enable <= 1'b0;
        clock_stop <= 1'b1;
        repeat (3) @(posedge pclk);
        clock_stop <= 1'b0;
        chip_enable <= 1'b1;
        rfs = 15;
        get(`IDX_REFERENCE_FREQUENCY_SELECT, 15);
        expect_synth();
        complete_run();
    end
endmodule : pll_synth_mode_and_disable_control_test

bind pll_synth_mode_and_disable_control pll_synth_props #(
    .CLOCK_HZ(CLOCK_HZ)) i_pll_synth_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
    .clock_stop(clock_stop), .low_band_vco_input(low_band_vco_input),
    .high_band_vco_input(high_band_vco_input), .vco_pulldown(vco_pulldown),
    .loop_amp_pulldown(loop_amp_pulldown), .err_out(err_out),
    .err_oe(err_oe), .ref_pulse(ref_pulse), .div_pulse(div_pulse));
